// ### pkg/mcuai_pkg.sv
package mcuai_pkg;
  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_OP = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  // Instruction word layout in the operation register.
  localparam int OPC_LSB = 0;
  localparam int OPC_W = 3;
  localparam int DEST_BIT = 3;
  localparam int FADDR_LSB = 8;
  localparam int FADDR_W = 6;
  // Operation codes written by software.
  localparam logic [2:0] OPC_NONE = 3'h0;
  localparam logic [2:0] OPC_DAA = 3'h1;
  localparam logic [2:0] OPC_DSZ = 3'h2;
  localparam logic [2:0] OPC_DEC = 3'h3;
  localparam logic [2:0] OPC_INC = 3'h4;
  localparam logic [2:0] OPC_IRQ_OFF = 3'h5;
  localparam logic [2:0] OPC_IRQ_ON = 3'h6;
  // Status register bit positions.
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_DC = 2;
  localparam int ST_GIE = 3;
  localparam int ST_BUSY = 4;
  // Reset values.
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  // Packed decimal correction constants.
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  // Execution sequencer states.
  typedef enum logic [1:0] {MCUAI_IDLE, MCUAI_EXEC, MCUAI_SKIP} mcuai_state_e;
endpackage : mcuai_pkg

// ### rtl/mcuai_core.sv
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
module mcuai_core (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // File register port.
  output logic [5:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic [7:0] file_wdata,
  output logic file_we,
  // Core side signals.
  output logic [7:0] accumulator,
  output logic global_irq_enable_bit,
  output logic skip_req
);

  mcuai_pkg::mcuai_state_e state_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [2:0] opc_reg;
  logic dest_reg;
  logic [5:0] faddr_reg;
  logic [7:0] acc_reg;
  logic c_reg;
  logic z_reg;
  logic dc_reg;
  logic gie_reg;
  logic [7:0] wdata_reg;
  logic we_reg;
  logic wr_op;
  logic wr_acc;
  logic wr_stat;
  logic exec;
  logic [7:0] arith_res;
  logic [8:0] daa_res;
  logic arith_op;

  // Packed decimal correction of a sum from its carries; bit 8 is the new carry.
  function automatic logic [8:0] mcuai_daa(input logic [7:0] v, input logic c, input logic dc);
    logic [7:0] t;
    logic hi_fix;
    t = v;
    hi_fix = c;
    if (dc || (v[3:0] > mcuai_pkg::BCD_MAX)) begin
      t = v + {4'h0, mcuai_pkg::BCD_FIX};
    end
    if (c || (v[7:4] > mcuai_pkg::BCD_MAX) || (t[7:4] > mcuai_pkg::BCD_MAX)) begin
      hi_fix = 1'b1;
      t = t + {mcuai_pkg::BCD_FIX, 4'h0};
    end
    return {hi_fix, t};
  endfunction : mcuai_daa

  // Bus decode; a request is acted on at the edge where ack is high.
  assign wr_op = ack_reg && wb_we_i && (wb_adr_i == mcuai_pkg::OFF_OP);
  assign wr_acc = ack_reg && wb_we_i && wb_sel_i[0] && (wb_adr_i == mcuai_pkg::OFF_ACC);
  assign wr_stat = ack_reg && wb_we_i && wb_sel_i[0] && (wb_adr_i == mcuai_pkg::OFF_STAT);
  assign exec = (state_reg == mcuai_pkg::MCUAI_EXEC);
  assign arith_op = (opc_reg == mcuai_pkg::OPC_DSZ) || (opc_reg == mcuai_pkg::OPC_DEC)
      || (opc_reg == mcuai_pkg::OPC_INC);

  // Result of the pending operation, modulo 256.
  always_comb begin
    if (opc_reg == mcuai_pkg::OPC_INC) begin
      arith_res = file_rdata + 8'h01;
    end else begin
      arith_res = file_rdata - 8'h01;
    end
    daa_res = mcuai_daa(acc_reg, c_reg, dc_reg);
  end

  // Single-cycle Wishbone answer with registered read data.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      case (wb_adr_i)
        mcuai_pkg::OFF_OP: rdat_reg <= {18'h0_0000, faddr_reg, 4'h0, dest_reg, opc_reg};
        mcuai_pkg::OFF_ACC: rdat_reg <= {24'h00_0000, acc_reg};
        mcuai_pkg::OFF_STAT: rdat_reg <= {27'h000_0000, (state_reg != mcuai_pkg::MCUAI_IDLE),
            gie_reg, dc_reg, z_reg, c_reg};
        default: rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Instruction latch; a new one is refused while the sequencer is busy.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      opc_reg <= mcuai_pkg::OPC_NONE;
      dest_reg <= 1'b0;
      faddr_reg <= 6'h00;
    end else if (wr_op && (state_reg == mcuai_pkg::MCUAI_IDLE)) begin
      if (wb_sel_i[0]) begin
        opc_reg <= wb_dat_i[mcuai_pkg::OPC_LSB +: mcuai_pkg::OPC_W];
        dest_reg <= wb_dat_i[mcuai_pkg::DEST_BIT];
      end
      if (wb_sel_i[1]) begin
        faddr_reg <= wb_dat_i[mcuai_pkg::FADDR_LSB +: mcuai_pkg::FADDR_W];
      end
    end
  end

  // Sequencer: one execute cycle, plus a discard cycle on a zero decrement-skip.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= mcuai_pkg::MCUAI_IDLE;
    end else begin
      case (state_reg)
        mcuai_pkg::MCUAI_IDLE: begin
          if (wr_op && wb_sel_i[0]) begin
            state_reg <= mcuai_pkg::MCUAI_EXEC;
          end
        end
        mcuai_pkg::MCUAI_EXEC: begin
          if ((opc_reg == mcuai_pkg::OPC_DSZ) && (arith_res == 8'h00)) begin
            state_reg <= mcuai_pkg::MCUAI_SKIP;
          end else begin
            state_reg <= mcuai_pkg::MCUAI_IDLE;
          end
        end
        default: state_reg <= mcuai_pkg::MCUAI_IDLE;
      endcase
    end
  end

  // Accumulator; execution takes precedence over a bus write.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg <= mcuai_pkg::ACC_RST;
    end else if (exec && (opc_reg == mcuai_pkg::OPC_DAA)) begin
      acc_reg <= daa_res[7:0];
    end else if (exec && arith_op && !dest_reg) begin
      acc_reg <= arith_res;
    end else if (wr_acc) begin
      acc_reg <= wb_dat_i[7:0];
    end
  end

  // Flags and global enable; execution takes precedence over a bus write.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {gie_reg, dc_reg, z_reg, c_reg} <= mcuai_pkg::FLAGS_RST;
    end else if (exec) begin
      case (opc_reg)
        mcuai_pkg::OPC_DAA: c_reg <= daa_res[8];
        mcuai_pkg::OPC_DEC: z_reg <= (arith_res == 8'h00);
        mcuai_pkg::OPC_INC: z_reg <= (arith_res == 8'h00);
        mcuai_pkg::OPC_IRQ_OFF: gie_reg <= 1'b0;
        mcuai_pkg::OPC_IRQ_ON: gie_reg <= 1'b1;
        default: c_reg <= c_reg;
      endcase
    end else if (wr_stat) begin
      c_reg <= wb_dat_i[mcuai_pkg::ST_C];
      z_reg <= wb_dat_i[mcuai_pkg::ST_Z];
      dc_reg <= wb_dat_i[mcuai_pkg::ST_DC];
      gie_reg <= wb_dat_i[mcuai_pkg::ST_GIE];
    end
  end

  // File register write-back, one cycle after execution.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      we_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end else begin
      we_reg <= exec && arith_op && dest_reg;
      if (exec && arith_op) begin
        wdata_reg <= arith_res;
      end
    end
  end

  // Output drive.
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign file_addr = faddr_reg;
  assign file_wdata = wdata_reg;
  assign file_we = we_reg;
  assign accumulator = acc_reg;
  assign global_irq_enable_bit = gie_reg;
  assign skip_req = (state_reg == mcuai_pkg::MCUAI_SKIP);

  chk_daa_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
      exec && (opc_reg == mcuai_pkg::OPC_DAA) |=> (acc_reg == $past(daa_res[7:0]))
      && (c_reg == $past(daa_res[8])) && $stable(z_reg) && (state_reg == mcuai_pkg::MCUAI_IDLE))
    else $error("decimal adjust result or flags wrong");

  chk_dsz_target: assert property (@(posedge sys_clk) disable iff (!rst_b)
      exec && (opc_reg == mcuai_pkg::OPC_DSZ) && dest_reg |=> file_we
      && (file_wdata == $past(file_rdata) - 8'h01) && $stable(acc_reg))
    else $error("decrement-skip write-back wrong");

  chk_skip_two: assert property (@(posedge sys_clk) disable iff (!rst_b)
      exec && (opc_reg == mcuai_pkg::OPC_DSZ) && (file_rdata == 8'h01)
      |=> skip_req ##1 (!skip_req && (state_reg == mcuai_pkg::MCUAI_IDLE)))
    else $error("zero decrement-skip did not discard one cycle");

  chk_noskip_one: assert property (@(posedge sys_clk) disable iff (!rst_b)
      exec && (file_rdata != 8'h01) |=> !skip_req)
    else $error("skip raised on nonzero result");

  chk_dec_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
      exec && (opc_reg == mcuai_pkg::OPC_DEC) && !dest_reg
      |=> (acc_reg == $past(file_rdata) - 8'h01) && (z_reg == (acc_reg == 8'h00)) && !file_we)
    else $error("decrement to accumulator wrong");

  chk_irq_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
      exec && (opc_reg == mcuai_pkg::OPC_IRQ_OFF) |=> !global_irq_enable_bit)
    else $error("global enable not cleared");

  chk_irq_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
      exec && (opc_reg == mcuai_pkg::OPC_IRQ_ON)
      |=> global_irq_enable_bit && $stable({c_reg, z_reg, dc_reg}) && !exec)
    else $error("global enable set wrongly");

  chk_inc_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
      exec && (opc_reg == mcuai_pkg::OPC_INC) && dest_reg && ($past(acc_reg) == acc_reg)
      |=> file_we && (file_wdata == $past(file_rdata) + 8'h01)
      && (z_reg == ($past(file_rdata) == 8'hff)) ##1 !file_we)
    else $error("increment write-back or zero flag wrong");

endmodule : mcuai_core

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  // Bench-driven inputs and design outputs.
  logic sys_clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, d, ack, fwe, acc_irq, skip;
  logic [7:0] adr = 8'h00, m_acc, r, acc_o, fwd;
  logic [3:0] sel = 4'hf, m_st;
  logic [31:0] dat = 32'h0000_0000, rd, dat_o;
  logic [5:0] fad, a;
  logic [2:0] op;
  logic [7:0] mem [64];
  int miscompares = 0, n_checks = 0, seed = 32'h04d3, cycles = 0, n_skip, n_we, ba, bb, sum;
  assign r = mem[fad];
  mcuai_core dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .file_addr(fad), .file_rdata(r), .file_wdata(fwd), .file_we(fwe),
    .accumulator(acc_o), .global_irq_enable_bit(acc_irq), .skip_req(skip));
  // Free-running clock.
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // Register file in the bench; also counts strobes, and cuts a hang short.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (fwe === 1'b1) mem[fad] <= fwd;
    if (fwe === 1'b1) n_we <= n_we + 1;
    if (skip === 1'b1) n_skip <= n_skip + 1;
    if (cycles == 30000) begin
      miscompares++;
      give_verdict();
    end
  end
  // One classic Wishbone cycle; data is taken and the request released at the edge of ack.
  task wb(input logic [7:0] ad, input logic w, input logic [31:0] wd, output logic [31:0] q);
    @(posedge sys_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, ad, wd};
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask : wb
  // Data comparison.
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) miscompares++;
    if (g !== e) $display("[FAIL] %s expected %h seen %h", nm, e, g);
  endtask : chk
  // Pulse count comparison.
  task chk_cnt(input string nm, input int e, input int g);
    n_checks++;
    if (g != e) miscompares++;
    if (g != e) $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
  endtask : chk_cnt
  // Loads accumulator and status through the bus; the busy bit is read-only and is not loaded.
  task setup(input logic [7:0] av, input logic [31:0] sv);
    wb(mcuai_pkg::OFF_ACC, 1'b1, {24'h00_0000, av}, rd);
    wb(mcuai_pkg::OFF_STAT, 1'b1, sv, rd);
    m_acc = av;
    m_st = sv[3:0];
  endtask : setup
  // Runs one operation against the reference model and compares every result.
  task run_op();
    logic [7:0] e_mem, t;
    int e_skip, e_we;
    e_mem = mem[a];
    e_skip = 0;
    e_we = 0;
    t = (op == mcuai_pkg::OPC_INC) ? mem[a] + 8'h01 : mem[a] - 8'h01;
    case (op)
      mcuai_pkg::OPC_DAA: begin
        e_we = (m_acc > 8'h99) || m_st[0];
        if ((m_acc[3:0] > 4'h9) || m_st[2]) m_acc = m_acc + 8'h06;
        if (e_we != 0) m_acc = m_acc + 8'h60;
        m_st[0] = (e_we != 0);
        e_we = 0;
      end
      mcuai_pkg::OPC_IRQ_OFF: m_st[3] = 1'b0;
      mcuai_pkg::OPC_IRQ_ON: m_st[3] = 1'b1;
      default: begin
        if (d) e_mem = t;
        else m_acc = t;
        e_we = d;
        if (op != mcuai_pkg::OPC_DSZ) m_st[1] = (t == 8'h00);
        e_skip = (op == mcuai_pkg::OPC_DSZ) && (t == 8'h00);
      end
    endcase
    n_skip = 0;
    n_we = 0;
    wb(mcuai_pkg::OFF_OP, 1'b1, {18'h0_0000, a, 4'h0, d, op}, rd);
    rd = 32'h0000_0010;
    for (int i = 0; i < 8 && rd[mcuai_pkg::ST_BUSY] !== 1'b0; i++)
      wb(mcuai_pkg::OFF_STAT, 1'b0, 0, rd);
    chk("status", {28'h000_0000, m_st}, rd);
    wb(mcuai_pkg::OFF_ACC, 1'b0, 0, rd);
    chk("acc", {24'h00_0000, m_acc}, rd);
    chk("acc port", {24'h00_0000, m_acc}, {24'h00_0000, acc_o});
    chk("irq enable", {31'h0, m_st[3]}, {31'h0, acc_irq});
    chk("file", {24'h00_0000, e_mem}, {24'h00_0000, mem[a]});
    chk_cnt("skip", e_skip, n_skip);
    chk_cnt("file write", e_we, n_we);
  endtask : run_op
  // Count summary, then the verdict.
  task give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // Main sequence: reset values, an unmapped place, the decimal example, then random operations.
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = $random(seed);
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    wb(mcuai_pkg::OFF_STAT, 1'b0, 0, rd);
    chk("reset status", 32'h0000_0000, rd);
    wb(8'h0c, 1'b1, 32'hffff_ffff, rd);
    wb(8'h0c, 1'b0, 0, rd);
    chk("unmapped", 32'h0000_0000, rd);
    setup(8'h4d, 32'h0000_0000);
    op = mcuai_pkg::OPC_DAA;
    {a, d} = 7'h00;
    run_op();
    for (int k = 0; k < 240; k++) begin
      op = 3'(k % 6 + 1);
      {a, d} = 7'($random(seed));
      mem[a] = (k % 4 == 0) ? 8'h00 : (k % 4 == 1) ? 8'h01 : (k % 4 == 2) ? 8'hff : 8'($random(seed));
      ba = (k * 37) % 100;
      bb = $unsigned($random(seed)) % 100;
      sum = (ba / 10 * 16 + ba % 10) + (bb / 10 * 16 + bb % 10);
      if (op == mcuai_pkg::OPC_DAA)
        setup(8'(sum), {28'h000_0000, 1'($random(seed)), ba % 10 + bb % 10 > 15, 1'b0, sum > 255});
      else setup(8'($random(seed)), $random(seed));
      run_op();
    end
    give_verdict();
  end
endmodule : testbench
